/* File: clock_ctrl_pkg.sv */
// package for the clock select and prescale block
// assumes a 25 MHz system clock and a 32-bit avalon-mm register port
package clock_ctrl_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned DELAY_SHORT_MS = 4;
  localparam int unsigned DELAY_LONG_MS = 64;
  localparam int unsigned WAKE_BOD_US = 60;
  localparam int unsigned DELAY_SHORT_CYC = CLK_HZ / 1000 * DELAY_SHORT_MS;
  localparam int unsigned DELAY_LONG_CYC = CLK_HZ / 1000 * DELAY_LONG_MS;
  localparam int unsigned WAKE_BOD_CYC = CLK_HZ / 1000000 * WAKE_BOD_US;
  localparam int unsigned RESET_CK = 14;
  localparam int unsigned START_258_CK = 258;
  localparam int unsigned START_1K_CK = 1024;
  localparam int unsigned START_16K_CK = 16384;
  localparam int unsigned CHANGE_WINDOW = 4;
  localparam int unsigned CNT_W = 24;
  // register byte addresses
  localparam logic [3:0] ADDR_TRIM = 4'h0;
  localparam logic [3:0] ADDR_PRESCALE = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  // prescale register fields
  localparam int unsigned PCE_BIT = 7;
  localparam logic [3:0] DIV_RESET_DIV8 = 4'h3;
  localparam logic [3:0] DIV_RESET_DIV1 = 4'h0;
  localparam logic [3:0] DIV_MAX_CODE = 4'h8;
  localparam int unsigned TRIM_RANGE_BIT = 7;
  // oscillator range fuse codes
  localparam logic [2:0] RANGE_0P4 = 3'h4;
  localparam logic [2:0] RANGE_0P9 = 3'h5;
  localparam logic [2:0] RANGE_3P0 = 3'h6;
  localparam logic [2:0] RANGE_8P0 = 3'h7;
  localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_INTERNAL_RC = 4'h2;
  typedef enum logic [1:0] {ADD_NONE, ADD_SHORT, ADD_LONG} add_delay_t;
endpackage : clock_ctrl_pkg

/* File: startup_decode.sv */
`timescale 1ns/1ps
// start-up delay decode from fuse values
// assumes fuses are stable while this is read
module startup_decode
  import clock_ctrl_pkg::*;
(
  input wire logic startup_group_fuse_in,
  input wire logic [1:0] startup_time_fuses_in,
  output logic [15:0] start_ck_out,
  output add_delay_t add_delay_out
);
  // crystal start-up table
  always_comb
  begin
    case ({startup_group_fuse_in, startup_time_fuses_in})
      3'h0: begin start_ck_out = 16'(START_258_CK); add_delay_out = ADD_SHORT; end
      3'h1: begin start_ck_out = 16'(START_258_CK); add_delay_out = ADD_LONG; end
      3'h2: begin start_ck_out = 16'(START_1K_CK); add_delay_out = ADD_NONE; end
      3'h3: begin start_ck_out = 16'(START_1K_CK); add_delay_out = ADD_SHORT; end
      3'h4: begin start_ck_out = 16'(START_1K_CK); add_delay_out = ADD_LONG; end
      3'h5: begin start_ck_out = 16'(START_16K_CK); add_delay_out = ADD_NONE; end
      3'h6: begin start_ck_out = 16'(START_16K_CK); add_delay_out = ADD_SHORT; end
      default: begin start_ck_out = 16'(START_16K_CK); add_delay_out = ADD_LONG; end
    endcase
  end
endmodule : startup_decode

/* File: ripple_prescaler.sv */
`timescale 1ns/1ps
// prescale counter making a one-cycle enable per divided clock
// assumes division code is held stable except at boundaries
module ripple_prescaler
  import clock_ctrl_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic [3:0] division_select_in,
  output logic tick_out
);
  typedef struct packed {
    logic [7:0] count;
    logic [3:0] active_div;
  } ps_state_t;
  ps_state_t st;
  ps_state_t next_st;
  logic [7:0] mask;
  // mask of counter bits for the active factor
  always_comb
  begin
    mask = 8'((9'h001 << st.active_div) - 9'h001);
  end
  // new factor applied only at a divided edge, so no short periods
  always_comb
  begin
    next_st = st;
    tick_out = ((st.count & mask) == mask);
    if (tick_out)
    begin
      next_st.count = 8'h00;
      next_st.active_div = division_select_in;
    end
    else
    begin
      next_st.count = st.count + 8'h01;
    end
  end
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      st <= '0;
    else
      st <= next_st;
  end
endmodule : ripple_prescaler

/* File: clock_select_prescale.sv */
`timescale 1ns/1ps
// clock select, start-up delay, prescaler control, clock output and trim register
// assumes avalon-mm master on sys_clk_in; fuses static after power-on
// Behaviour
// - range fuses 100..111 choose oscillator amplifier range
// - group fuse and time fuses select 258, 1K or 16K start-up cycles
// - after reset wait 14 cycles plus optional 4 ms or 64 ms
// - with detector off, wake-up from sleep stretched to about 60 us
// - default is internal 8 MHz source, longest start, divide by eight
// - one division factor applies to all clock domains
// - factor change makes no glitch, no faster intermediate clock
// - prescaler counts on undivided clock, state not readable
// - new factor active between T1+T2 and T1+2*T2
// - exactly two active edges during the change interval
// - clock-out fuse drives system clock on pin, overriding I/O
// - no clock on the output pin during reset
// - output pin carries the prescaled clock
// - factory calibration loaded into trim register at reset
// - trim write retunes the oscillator at once
// - top trim bit picks low or high overlapping range
// - lower seven bits tune within range, 0x00 low to 0x7F high
// - codes 0..8 divide by 1..256, higher codes reserved
// - change enable alone, then factor within four cycles; cleared after
// - division resets to 0011 with divide-by-eight fuse, else 0000
module clock_select_prescale
  import clock_ctrl_pkg::*;
#(
  parameter int unsigned SHORT_DELAY_CYC = DELAY_SHORT_CYC,
  parameter int unsigned LONG_DELAY_CYC = DELAY_LONG_CYC,
  parameter int unsigned WAKE_DELAY_CYC = WAKE_BOD_CYC,
  parameter logic [7:0] FACTORY_TRIM = 8'h80
)
(
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic [3:0] clock_source_select_fuses_in,
  input wire logic [1:0] startup_time_fuses_in,
  input wire logic divide_by_eight_fuse_in,
  input wire logic clock_pin_drive_fuse_in,
  input wire logic brownout_detector_off_in,
  input wire logic sleep_wake_in,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  output logic [2:0] oscillator_range_out,
  output logic amp_enable_out,
  output logic [7:0] oscillator_trim_out,
  output logic sys_clk_enable_out,
  output logic run_enable_out,
  output logic clock_pin_out,
  output logic clock_pin_oe_n_out
);
  typedef enum logic [2:0] {ST_LATCH, ST_OSC_START, ST_RESET_CK, ST_ADD_DELAY, ST_RUN, ST_WAKE} phase_t;
  typedef struct packed {
    phase_t phase;
    logic [CNT_W-1:0] count;
    logic [3:0] clock_source_select_fuses;
    logic [1:0] sut;
    logic div8;
    logic clock_pin_drive_fuse;
    logic [7:0] trim;
    logic [3:0] division_select;
    logic prescale_change_enable;
    logic [2:0] pce_age;
    logic ack;
    logic [31:0] rdata;
    logic [1:0] resp;
    logic clk_pin;
  } state_t;
  state_t st;
  state_t next_st;
  logic [15:0] start_ck;
  add_delay_t add_delay;
  add_delay_t add_sel;
  logic tick;
  logic ext_osc;
  logic wr_req;
  logic rd_req;
  logic byte0;
  logic [7:0] wbyte;
  logic [CNT_W-1:0] add_cycles;

  startup_decode u_startup_decode (
    .startup_group_fuse_in(st.clock_source_select_fuses[0]),
    .startup_time_fuses_in(st.sut),
    .start_ck_out(start_ck),
    .add_delay_out(add_delay)
  );

  ripple_prescaler u_ripple_prescaler (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .division_select_in(st.division_select),
    .tick_out(tick)
  );

  // crystal mode is any code with the top fuse bit set
  assign ext_osc = st.clock_source_select_fuses[3];
  assign oscillator_range_out = st.clock_source_select_fuses[3:1];
  assign amp_enable_out = ext_osc && (st.phase != ST_LATCH);
  assign oscillator_trim_out = st.trim;
  assign run_enable_out = (st.phase == ST_RUN);
  assign sys_clk_enable_out = tick && (st.phase == ST_RUN);
  assign clock_pin_out = st.clk_pin;
  assign clock_pin_oe_n_out = !(st.clock_pin_drive_fuse && st.phase != ST_LATCH);
  // bus handshake
  assign wr_req = avs_write && !st.ack;
  assign rd_req = avs_read && !st.ack;
  assign avs_waitrequest = (avs_read || avs_write) && !st.ack;
  assign avs_readdata = st.rdata;
  assign avs_response = st.resp;
  assign byte0 = avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];

  // additional reset delay length; crystal codes use the shared table, other sources the time fuses alone
  always_comb
  begin
    add_sel = add_delay;
    if (!ext_osc)
    begin
      case (st.sut)
        2'h1: add_sel = ADD_SHORT;
        2'h2: add_sel = ADD_LONG;
        default: add_sel = ADD_NONE;
      endcase
    end
    case (add_sel)
      ADD_SHORT: add_cycles = CNT_W'(SHORT_DELAY_CYC);
      ADD_LONG: add_cycles = CNT_W'(LONG_DELAY_CYC);
      default: add_cycles = '0;
    endcase
  end

  // next-state logic
  always_comb
  begin
    next_st = st;
    next_st.ack = 1'b0;
    case (st.phase)
      ST_LATCH:
      begin
        // capture fuses once, after reset release
        next_st.clock_source_select_fuses = clock_source_select_fuses_in;
        next_st.sut = startup_time_fuses_in;
        next_st.div8 = divide_by_eight_fuse_in;
        next_st.clock_pin_drive_fuse = clock_pin_drive_fuse_in;
        next_st.division_select = divide_by_eight_fuse_in ? DIV_RESET_DIV8 : DIV_RESET_DIV1;
        next_st.count = '0;
        next_st.phase = clock_source_select_fuses_in[3] ? ST_OSC_START : ST_RESET_CK;
      end
      ST_OSC_START:
      begin
        // oscillator settle count, crystal source only
        next_st.count = st.count + 1'b1;
        if (st.count >= CNT_W'(start_ck) - 1'b1)
        begin
          next_st.count = '0;
          next_st.phase = ST_RESET_CK;
        end
      end
      ST_RESET_CK:
      begin
        next_st.count = st.count + 1'b1;
        if (st.count >= CNT_W'(RESET_CK) - 1'b1)
        begin
          next_st.count = '0;
          // the fixed table covers crystal codes; other sources use the time fuses alone
          next_st.phase = (add_cycles != '0) ? ST_ADD_DELAY : ST_RUN;
        end
      end
      ST_ADD_DELAY:
      begin
        next_st.count = st.count + 1'b1;
        if (st.count >= add_cycles - 1'b1)
        begin
          next_st.count = '0;
          next_st.phase = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (sleep_wake_in)
        begin
          next_st.count = '0;
          next_st.phase = ST_WAKE;
        end
      end
      ST_WAKE:
      begin
        // wake from sleep: crystal start cycles, or the fixed wake delay instead while detector is off
        next_st.count = st.count + 1'b1;
        if (brownout_detector_off_in)
        begin
          if (st.count >= CNT_W'(WAKE_DELAY_CYC) - 1'b1)
            next_st.phase = ST_RUN;
        end
        else if (!ext_osc || st.count >= CNT_W'(start_ck) - 1'b1)
        begin
          next_st.phase = ST_RUN;
        end
      end
      default:
      begin
        next_st.phase = ST_LATCH;
      end
    endcase

    // change-enable window ages out after four cycles
    if (st.prescale_change_enable)
    begin
      next_st.pce_age = st.pce_age + 3'h1;
      if (st.pce_age >= 3'(CHANGE_WINDOW - 1))
        next_st.prescale_change_enable = 1'b0;
    end

    // clock pin toggles on each divided edge, held low outside run
    if (st.phase == ST_RUN && tick)
      next_st.clk_pin = !st.clk_pin;
    else if (st.phase != ST_RUN)
      next_st.clk_pin = 1'b0;

    // register writes
    if (wr_req)
    begin
      next_st.ack = 1'b1;
      next_st.resp = 2'h0;
      case (avs_address)
        ADDR_TRIM:
        begin
          if (byte0)
            next_st.trim = wbyte;
        end
        ADDR_PRESCALE:
        begin
          if (byte0)
          begin
            if (wbyte == 8'h80)
            begin
              // set only from idle; rewrite neither extends nor clears
              if (!st.prescale_change_enable)
              begin
                next_st.prescale_change_enable = 1'b1;
                next_st.pce_age = 3'h0;
              end
            end
            else if (st.prescale_change_enable && !wbyte[PCE_BIT])
            begin
              next_st.prescale_change_enable = 1'b0;
              if (wbyte[3:0] <= DIV_MAX_CODE)
                next_st.division_select = wbyte[3:0];
              else
                next_st.resp = 2'h2;
            end
          end
        end
        ADDR_STATUS:
        begin
        end
        default:
        begin
          next_st.resp = 2'h3;
        end
      endcase
    end

    // register reads
    if (rd_req)
    begin
      next_st.ack = 1'b1;
      next_st.resp = 2'h0;
      next_st.rdata = 32'h0000_0000;
      case (avs_address)
        ADDR_TRIM: next_st.rdata = {24'h000000, st.trim};
        ADDR_PRESCALE: next_st.rdata = {24'h000000, st.prescale_change_enable, 3'h0, st.division_select};
        ADDR_STATUS: next_st.rdata = {20'h00000, 1'b0, st.phase, st.clock_pin_drive_fuse, st.div8, st.sut, st.clock_source_select_fuses};
        default: next_st.resp = 2'h3;
      endcase
    end
  end

  // state register; trim takes the factory value at reset
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st <= '0;
      st.phase <= ST_LATCH;
      st.clock_source_select_fuses <= CLOCK_SOURCE_SELECT_FUSES_INTERNAL_RC;
      st.sut <= 2'h2;
      st.div8 <= 1'b1;
      st.division_select <= DIV_RESET_DIV8;
      st.trim <= FACTORY_TRIM;
    end
    else
    begin
      st <= next_st;
    end
  end
endmodule : clock_select_prescale

/* File: resonator_model.sv */
`timescale 1ns/1ps
// behavioural resonator on the oscillator amplifier pins
// assumes range and amplifier enable come from the latched fuses
module resonator_model
#(
  parameter bit CERAMIC = 1'b1
)
(
  input wire logic amp_enable_in,
  input wire logic [2:0] range_in,
  output logic osc_ok_out
);
  // swings only with the amplifier on; lowest range needs a ceramic part
  assign osc_ok_out = amp_enable_in && (range_in != 3'h4 || CERAMIC);
endmodule : resonator_model

/* File: clock_select_prescale_sva.sv */
`timescale 1ns/1ps
// port checker for the clock select and prescale block
// assumes one clock domain and fuses held static out of reset
module clock_select_prescale_chk
  import clock_ctrl_pkg::*;
#(
  parameter logic [7:0] FACTORY_TRIM = 8'h80
)
(
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic [3:0] clock_source_select_fuses_in,
  input wire logic clock_pin_drive_fuse_in,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic [2:0] oscillator_range_out,
  input wire logic [7:0] oscillator_trim_out,
  input wire logic sys_clk_enable_out,
  input wire logic run_enable_out,
  input wire logic clock_pin_out,
  input wire logic clock_pin_oe_n_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!arst_n_in);
  // a request seen with the wait still up
  sequence taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  // first edge after reset release
  sequence released;
    $rose(arst_n_in);
  endsequence
  one_wait_a: assert property (taken |=> !avs_waitrequest)
    else $error("wait not lowered one cycle after request");
  idle_wait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("wait raised with no request");
  trim_write_a: assert property (taken ##0 (avs_write && avs_address == ADDR_TRIM && avs_byteenable[0])
    |=> oscillator_trim_out == 8'($past(avs_writedata)))
    else $error("trim not updated by write");
  trim_reset_a: assert property (released |-> oscillator_trim_out == FACTORY_TRIM)
    else $error("trim not factory value after reset");
  range_latch_a: assert property (released |=> oscillator_range_out == clock_source_select_fuses_in[3:1])
    else $error("range differs from fuses");
  run_late_a: assert property (released |-> !run_enable_out [*8])
    else $error("run too soon after reset");
  tick_run_a: assert property (sys_clk_enable_out |-> run_enable_out)
    else $error("clock enable outside run");
  pin_toggle_a: assert property (sys_clk_enable_out |=> clock_pin_out != $past(clock_pin_out))
    else $error("clock pin not toggled on divided edge");
  pin_drive_a: assert property (run_enable_out && clock_pin_drive_fuse_in |-> !clock_pin_oe_n_out)
    else $error("clock pin not driven with fuse set");
  pin_off_a: assert property (!clock_pin_drive_fuse_in |-> clock_pin_oe_n_out)
    else $error("pin driven with fuse clear");
  pin_quiet_a: assert property (released or (!run_enable_out [*2]) |-> !clock_pin_out)
    else $error("clock pin active outside run");
endmodule : clock_select_prescale_chk

bind clock_select_prescale clock_select_prescale_chk #(.FACTORY_TRIM(FACTORY_TRIM)) i_chk (.*);

/* File: testbench.sv */
`timescale 1ns/1ps
// self-checking bench for the clock select and prescale block
// assumes the resonator model and checker are compiled before it
module testbench;
  import clock_ctrl_pkg::*;
  typedef struct {logic [3:0] cks; logic [1:0] sut; logic d8; int cyc;} row_t;
  logic sys_clk_in = 0, arst_n_in = 0, divide_by_eight_fuse_in = 0, clock_pin_drive_fuse_in = 1;
  logic brownout_detector_off_in = 0, sleep_wake_in = 0, avs_read = 0, avs_write = 0, osc_ok, pin;
  logic [3:0] clock_source_select_fuses_in = 4'h2, avs_address = 4'h0, avs_byteenable = 4'h1;
  logic [1:0] startup_time_fuses_in = 2'h0, avs_response, rs;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic avs_waitrequest, amp_enable_out, sys_clk_enable_out, run_enable_out, clock_pin_out, clock_pin_oe_n_out;
  logic [2:0] oscillator_range_out;
  logic [7:0] oscillator_trim_out;
  int errors = 0, samples_checked = 0, n;
  // fuses beside expected cycles from release to run
  row_t rows [5] = '{'{4'h2, 2'h2, 1, 54}, '{4'h8, 2'h3, 0, 1058}, '{4'hA, 2'h1, 0, 312},
    '{4'hD, 2'h1, 1, 16398}, '{4'hF, 2'h2, 0, 16418}};

  // free-running 25 MHz clock
  always #20 sys_clk_in = ~sys_clk_in;

  clock_select_prescale #(.SHORT_DELAY_CYC(20), .LONG_DELAY_CYC(40), .WAKE_DELAY_CYC(10)) i_clock_select_prescale (.*);
  resonator_model i_resonator_model (.amp_enable_in(amp_enable_out), .range_in(oscillator_range_out), .osc_ok_out(osc_ok));

  task end_sim;
    if (errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // one avalon access, held until wait is seen low
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= d;
    do
      @(posedge sys_clk_in);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    rs = avs_response;
  endtask : bus

  task rel;
    avs_write <= 0;
    avs_read <= 0;
    @(posedge sys_clk_in);
  endtask : rel

  // cycles between two clock enable pulses
  task gap(output int g);
    int k;
    k = 0;
    g = 0;
    do
      @(posedge sys_clk_in);
    while (sys_clk_enable_out !== 1'b1 && ++k < 600);
    do
    begin
      @(posedge sys_clk_in);
      g++;
    end
    while (sys_clk_enable_out !== 1'b1 && g < 600);
  endtask : gap

  initial
  begin
    foreach (rows[i])
    begin
      arst_n_in <= 0;
      clock_source_select_fuses_in <= rows[i].cks;
      startup_time_fuses_in <= rows[i].sut;
      divide_by_eight_fuse_in <= rows[i].d8;
      clock_pin_drive_fuse_in <= !i[0];
      repeat (3) @(posedge sys_clk_in);
      arst_n_in <= 1;
      n = 0;
      while (run_enable_out !== 1'b1 && n < 20000)
      begin
        @(posedge sys_clk_in);
        n++;
      end
      // one latch edge and one sampling edge on top of the start-up cycles
      chk(n, rows[i].cyc + 2);
      chk(clock_pin_oe_n_out, !clock_pin_drive_fuse_in);
      chk(oscillator_range_out, rows[i].cks[3:1]);
      chk(osc_ok, rows[i].cks[3]);
      bus(0, ADDR_PRESCALE, 0);
      rel();
      chk(rd, rows[i].d8 ? 3 : 0);
      bus(0, ADDR_TRIM, 0);
      rel();
      chk(rd, 8'h80);
      gap(n);
      chk(n, rows[i].d8 ? 8 : 1);
    end
    // every division code, then a reserved one
    for (int c = 0; c <= 9; c++)
    begin
      bus(1, ADDR_PRESCALE, 32'h80);
      bus(1, ADDR_PRESCALE, 32'(c));
      chk(rs, c > 8 ? 2 : 0);
      rel();
      bus(0, ADDR_PRESCALE, 0);
      rel();
      chk(rd, c > 8 ? 8 : c);
      gap(n);
      gap(n);
      chk(n, 1 << (c > 8 ? 8 : c));
      pin = clock_pin_out;
      @(posedge sys_clk_in);
      chk(clock_pin_out, !pin);
    end
    // enable with other bits set, bare write, expired window: all ignored
    bus(1, ADDR_PRESCALE, 32'h81);
    bus(1, ADDR_PRESCALE, 32'h1);
    bus(1, ADDR_PRESCALE, 32'h80);
    rel();
    repeat (5) @(posedge sys_clk_in);
    bus(1, ADDR_PRESCALE, 32'h1);
    rel();
    bus(0, ADDR_PRESCALE, 0);
    rel();
    chk(rd, 8);
    bus(1, ADDR_TRIM, 32'h7F);
    rel();
    chk(oscillator_trim_out, 8'h7F);
    bus(0, 4'hC, 0);
    rel();
    chk(rs, 2'h3); // unmapped
    chk(rd, 32'h0); // unmapped
    // wake with detector off waits the fixed wake delay instead of the crystal start-up cycles
    brownout_detector_off_in <= 1;
    sleep_wake_in <= 1;
    @(posedge sys_clk_in);
    sleep_wake_in <= 0;
    repeat (2) @(posedge sys_clk_in);
    chk(run_enable_out, 0);
    n = 0;
    while (run_enable_out !== 1'b1 && n < 100)
    begin
      @(posedge sys_clk_in);
      n++;
    end
    // ten wake cycles, less the two already waited, plus the sampling edge
    chk(n, 9);
    end_sim();
  end

  // hang guard
  initial
  begin
    #(40 * 90000);
    errors++;
    end_sim();
  end
endmodule : testbench
